// File: core/fpa_defs.svh
`ifndef FPA_DEFS_SVH
`define FPA_DEFS_SVH
// device address and command codes
`define FPA_DEV_ADDR 8'h0A
`define FPA_CMD_RESET 8'h01
`define FPA_CMD_RD_BASIC_STATUS_WORD 8'h02
`define FPA_CMD_SET_BASIC_STATUS_WORD 8'h03
`define FPA_CMD_CLR_BASIC_STATUS_WORD 8'h04
`define FPA_CMD_RD_CTRL 8'h05
`define FPA_CMD_WR_CTRL 8'h06
`define FPA_CMD_RD_DLO 8'h07
`define FPA_CMD_RD_DHI 8'h08
`define FPA_CMD_WR_DLO 8'h09
`define FPA_CMD_WR_DHI 8'h0A
`define FPA_CMD_WR_CMPHI 8'h0B
`define FPA_CMD_WR_CMPLO 8'h0C
`define FPA_CMD_WR_CSET 8'h0D
`define FPA_CMD_RD_CSET 8'h0E
// control register bits
`define FPA_CTL_FETCH 0
`define FPA_CTL_STORE 1
`define FPA_CTL_STOPCHK 2
`define FPA_CTL_REG2 3
`define FPA_CTL_ATTN 4
`define FPA_CTL_KLOCK 5
// basic status word bits
`define FPA_BS_FCMP 0
`define FPA_BS_SCMP 1
`define FPA_BS_SYSCHK 2
`define FPA_BS_PANEL 3
`define FPA_BS_ACT0 4
`define FPA_BS_SEL0 8
`define FPA_BS_START 11
`define FPA_BS_STOP 12
`define FPA_BS_BADCMD 13
`define FPA_BS_INTEN 14
`define FPA_BS_EVTMASK 16'h38F7
`define FPA_BAD_OPCODE 16'hFFFF
// blink half period
`define FPA_BLINK_MS 250
`define FPA_CLK_KHZ 20000
`define FPA_BLINK_CYC (`FPA_BLINK_MS * `FPA_CLK_KHZ)
`endif

// File: core/fpa_pkg.sv
package fpa_pkg;
  typedef enum logic [1:0] {PNL_OFF, PNL_ARMED, PNL_ON} fpa_pnl_t;
  typedef logic [15:0] fpa_word_t;
endpackage

// File: core/fpa_panel.sv
`timescale 1ns/1ps
`include "fpa_defs.svh"
//////////////////////////////////////////////////////////////////////////////
module fpa_panel import fpa_pkg::*; #(
  parameter int NACT = 4,
  parameter int NSEL = 7,
  parameter int BLINK_CYC = `FPA_BLINK_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [15:0] busRdata,
  input wire logic memValid,
  input wire logic memStore,
  input wire logic [31:0] memAddr,
  input wire logic [2:0] memLevel,
  input wire logic memSecondary,
  input wire logic opValid,
  input wire logic [15:0] opCode,
  input wire logic sysCheckIn,
  input wire logic switchReq,
  input wire logic [NACT-1:0] btnAction,
  input wire logic [NSEL-1:0] btnSelect,
  input wire logic btnStart,
  input wire logic btnEnable,
  input wire logic btnClear,
  input wire logic btnReg1,
  input wire logic btnReg2,
  input wire logic keyValid,
  input wire logic [3:0] keyDigit,
  output logic intReq,
  output logic cmpStop,
  output logic progCheck,
  output logic switchGo,
  output logic sysCheckOut,
  output logic stopProc,
  output logic [31:0] hexDisplay,
  output logic reg1Led,
  output logic reg2Led,
  output logic attnLed,
  output logic kbdLockLed
);

  initial begin
    if (NACT < 1 || NACT > 4) $error("NACT must be 1 to 4");
    if (NSEL < 1 || NSEL > 7) $error("NSEL must be 1 to 7");
    if (BLINK_CYC < 2) $error("BLINK_CYC too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  fpa_word_t basic_status_word_q, basic_status_word_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [31:0] reg1_q, reg1_d, reg2_q, reg2_d;
  logic [31:0] cmpAddr_q, cmpAddr_d;
  logic [3:0] cset_q, cset_d;
  fpa_pnl_t pnl_q, pnl_d;
  logic [15:0] rdata_q, rdata_d;
  logic [NACT+NSEL+5:0] btn_q;
  logic [NACT+NSEL+5:0] btnNow;
  logic [NACT+NSEL+5:0] press;
  logic [31:0] blink_q, blink_d;
  logic attn_q, attn_d;
  logic int_q, int_d;
  logic cmp_q, cmp_d;
  logic pchk_q, pchk_d;
  logic excPend_q, excPend_d;
  logic swGo_q, swGo_d;
  logic swPend_q, swPend_d;
  logic syschk_q, syschk_d;
  logic stop_q, stop_d;
  logic [31:0] disp_q, disp_d;
  logic led1_q, led1_d, led2_q, led2_d;
  logic kbdLock_q, kbdLock_d;

  // press edges; buttons held for many cycles count once
  assign btnNow = {keyValid, btnReg2, btnReg1, btnClear, btnEnable, btnStart, btnSelect, btnAction};
  assign press = btnNow & ~btn_q;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  logic ours, badCmd, hit, lvlOk, excNow, excAll, swAll, pbOn, sysEvt, rdCode, stopEvt;
  logic [31:0] sel;
  logic [2:0] selCode;
  always_comb begin
    basic_status_word_d = basic_status_word_q;
    ctrl_d = ctrl_q;
    reg1_d = reg1_q;
    reg2_d = reg2_q;
    cmpAddr_d = cmpAddr_q;
    cset_d = cset_q;
    pnl_d = pnl_q;
    rdata_d = 16'h0000;
    badCmd = 1'b0;
    selCode = 3'h0;
    sel = ctrl_q[`FPA_CTL_REG2] ? reg2_q : reg1_q;
    ours = (busAddr[15:8] == `FPA_DEV_ADDR) && (busWr || busRd);
    pbOn = (pnl_q == PNL_ON);
    // a read code issued as a write, or the reverse, is refused as a bad command
    rdCode = (busAddr[7:0] == `FPA_CMD_RD_BASIC_STATUS_WORD) || (busAddr[7:0] == `FPA_CMD_RD_CTRL) ||
             (busAddr[7:0] == `FPA_CMD_RD_DLO) || (busAddr[7:0] == `FPA_CMD_RD_DHI) ||
             (busAddr[7:0] == `FPA_CMD_RD_CSET);
    if (ours && (busRd != rdCode)) badCmd = 1'b1;

    // software commands; writes land first, hardware sets below win
    if (ours && !badCmd) begin
      case (busAddr[7:0])
        `FPA_CMD_RESET: begin
          basic_status_word_d = 16'h0000;
          ctrl_d = 8'h00;
          reg1_d = 32'h0000_0000;
          reg2_d = 32'h0000_0000;
          cmpAddr_d = 32'h0000_0000;
          cset_d = 4'h0;
          pnl_d = PNL_OFF;
        end
        `FPA_CMD_RD_BASIC_STATUS_WORD: rdata_d = basic_status_word_q;
        `FPA_CMD_SET_BASIC_STATUS_WORD: basic_status_word_d = basic_status_word_q | busWdata;
        `FPA_CMD_CLR_BASIC_STATUS_WORD: basic_status_word_d = basic_status_word_q & ~busWdata;
        `FPA_CMD_RD_CTRL: rdata_d = {8'h00, ctrl_q};
        `FPA_CMD_WR_CTRL: ctrl_d = busWdata[7:0];
        `FPA_CMD_RD_DLO: rdata_d = sel[15:0];
        `FPA_CMD_RD_DHI: rdata_d = sel[31:16];
        `FPA_CMD_WR_DLO, `FPA_CMD_WR_DHI: begin
          if (busAddr[7:0] == `FPA_CMD_WR_DLO) sel[15:0] = busWdata;
          else sel[31:16] = busWdata;
          if (ctrl_q[`FPA_CTL_REG2]) reg2_d = sel;
          else reg1_d = sel;
        end
        `FPA_CMD_WR_CMPHI: cmpAddr_d[31:16] = busWdata;
        `FPA_CMD_WR_CMPLO: cmpAddr_d[15:0] = busWdata;
        `FPA_CMD_WR_CSET: cset_d = busWdata[3:0];
        `FPA_CMD_RD_CSET: rdata_d = {12'h000, cset_q};
        default: badCmd = 1'b1;
      endcase
    end

    // address compare; level 0 in setup means any level
    lvlOk = (cset_q[2:0] == 3'h0) ||
            ((cset_q[2:0] == memLevel) && (cset_q[3] == memSecondary));
    // a not-taken branch issues no access, so memValid stays low
    hit = memValid && (memAddr == cmpAddr_q) && lvlOk &&
          (memStore ? ctrl_q[`FPA_CTL_STORE] : ctrl_q[`FPA_CTL_FETCH]);
    if (hit && !memStore) basic_status_word_d[`FPA_BS_FCMP] = 1'b1;
    if (hit && memStore) basic_status_word_d[`FPA_BS_SCMP] = 1'b1;

    // exception and vector switch wait one cycle behind a compare
    excNow = opValid && (opCode == `FPA_BAD_OPCODE);
    excAll = excNow || excPend_q;
    excPend_d = excAll && hit;
    pchk_d = excAll && !hit;
    swAll = switchReq || swPend_q;
    swPend_d = swAll && hit;
    swGo_d = swAll && !hit;
    cmp_d = hit;

    // checks and the stop they may cause
    sysEvt = badCmd || sysCheckIn;
    syschk_d = sysEvt;
    if (badCmd) basic_status_word_d[`FPA_BS_BADCMD] = 1'b1;
    if (sysEvt) basic_status_word_d[`FPA_BS_SYSCHK] = 1'b1;
    stop_d = stop_q;
    stopEvt = ctrl_q[`FPA_CTL_STOPCHK] && (sysEvt || pchk_d);
    if (stopEvt) begin
      stop_d = 1'b1;
      basic_status_word_d[`FPA_BS_STOP] = 1'b1;
    end

    // pushbuttons
    if (pbOn) begin
      for (int i = 0; i < NACT; i++) begin
        if (press[i]) basic_status_word_d[`FPA_BS_ACT0 + i] = 1'b1;
      end
      for (int i = 0; i < NSEL; i++) begin
        if (press[NACT + i]) selCode = 3'(i + 1);
      end
      if (selCode != 3'h0) basic_status_word_d[`FPA_BS_SEL0 +: 3] = selCode;
      if (press[NACT + NSEL]) begin
        basic_status_word_d[`FPA_BS_START] = 1'b1;
        stop_d = stopEvt; // a stop event in the same cycle outlives Start
      end
      if (press[NACT + NSEL + 3]) ctrl_d[`FPA_CTL_REG2] = 1'b0;
      if (press[NACT + NSEL + 4]) ctrl_d[`FPA_CTL_REG2] = 1'b1;
      if (press[NACT + NSEL + 5] && !ctrl_q[`FPA_CTL_KLOCK]) begin
        if (ctrl_q[`FPA_CTL_REG2]) reg2_d = {reg2_q[27:0], keyDigit};
        else reg1_d = {reg1_q[27:0], keyDigit};
      end
      if (press[NACT + NSEL + 2]) begin
        basic_status_word_d[`FPA_BS_PANEL] = 1'b0;
        reg1_d = 32'h0000_0000;
        reg2_d = 32'h0000_0000;
        ctrl_d[`FPA_CTL_ATTN] = 1'b0;
        ctrl_d[`FPA_CTL_REG2] = 1'b0;
      end
    end

    // enable arms (or turns an enabled panel off), Start completes the enable; enable works while off
    if (press[NACT + NSEL + 1]) pnl_d = (pnl_q == PNL_ON) ? PNL_OFF : PNL_ARMED;
    else if (pnl_q == PNL_ARMED && press[NACT + NSEL]) begin
      pnl_d = PNL_ON;
      basic_status_word_d[`FPA_BS_PANEL] = 1'b1;
      basic_status_word_d[`FPA_BS_INTEN] = 1'b1;
    end

    // interrupt is a level off the sticky bits
    int_d = basic_status_word_d[`FPA_BS_INTEN] && ((basic_status_word_d & `FPA_BS_EVTMASK) != 16'h0000);

    // display follows the next selection so it never lags a write
    disp_d = ctrl_d[`FPA_CTL_REG2] ? reg2_d : reg1_d;
    led1_d = !ctrl_d[`FPA_CTL_REG2];
    led2_d = ctrl_d[`FPA_CTL_REG2];
    kbdLock_d = ctrl_q[`FPA_CTL_KLOCK]; // indicator trails the lock bit

    // blink runs regardless of panel enable
    blink_d = blink_q;
    attn_d = 1'b0;
    if (ctrl_q[`FPA_CTL_ATTN]) begin
      attn_d = attn_q;
      if (blink_q >= 32'(BLINK_CYC - 1)) begin
        blink_d = 32'h0000_0000;
        attn_d = !attn_q;
      end else begin
        blink_d = blink_q + 32'h0000_0001;
      end
    end else begin
      blink_d = 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      basic_status_word_q <= 16'h0000;
      ctrl_q <= 8'h00;
      reg1_q <= 32'h0000_0000;
      reg2_q <= 32'h0000_0000;
      cmpAddr_q <= 32'h0000_0000;
      cset_q <= 4'h0;
      pnl_q <= PNL_OFF;
      rdata_q <= 16'h0000;
      btn_q <= '0;
      blink_q <= 32'h0000_0000;
      attn_q <= 1'b0;
      int_q <= 1'b0;
      cmp_q <= 1'b0;
      pchk_q <= 1'b0;
      excPend_q <= 1'b0;
      swGo_q <= 1'b0;
      swPend_q <= 1'b0;
      syschk_q <= 1'b0;
      stop_q <= 1'b0;
      disp_q <= 32'h0000_0000;
      led1_q <= 1'b1;
      led2_q <= 1'b0;
      kbdLock_q <= 1'b0;
    end else begin
      basic_status_word_q <= basic_status_word_d;
      ctrl_q <= ctrl_d;
      reg1_q <= reg1_d;
      reg2_q <= reg2_d;
      cmpAddr_q <= cmpAddr_d;
      cset_q <= cset_d;
      pnl_q <= pnl_d;
      rdata_q <= rdata_d;
      btn_q <= btnNow;
      blink_q <= blink_d;
      attn_q <= attn_d;
      int_q <= int_d;
      cmp_q <= cmp_d;
      pchk_q <= pchk_d;
      excPend_q <= excPend_d;
      swGo_q <= swGo_d;
      swPend_q <= swPend_d;
      syschk_q <= syschk_d;
      stop_q <= stop_d;
      disp_q <= disp_d;
      led1_q <= led1_d;
      led2_q <= led2_d;
      kbdLock_q <= kbdLock_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  assign busRdata = rdata_q;
  assign intReq = int_q;
  assign cmpStop = cmp_q;
  assign progCheck = pchk_q;
  assign switchGo = swGo_q;
  assign sysCheckOut = syschk_q;
  assign stopProc = stop_q;
  assign hexDisplay = disp_q;
  assign reg1Led = led1_q;
  assign reg2Led = led2_q;
  assign attnLed = attn_q;
  assign kbdLockLed = kbdLock_q;

endmodule

// File: core/fpa_panel_tail.sv
`timescale 1ns/1ps

// File: verif/fpa_cpu.sv
`timescale 1ns/1ps
`include "fpa_defs.svh"
//////////////////////////////////////////////////////////////////////////////
// processor side: storage accesses, opcodes, vector switches, check events
module fpa_cpu (
  input wire logic mclk,
  output logic memValid,
  output logic memStore,
  output logic [31:0] memAddr,
  output logic [2:0] memLevel,
  output logic memSecondary,
  output logic opValid,
  output logic [15:0] opCode,
  output logic switchReq,
  output logic sysCheckIn
);
  // idle at time zero
  initial begin
    {memValid, memStore, opValid, switchReq, sysCheckIn, memSecondary} = '0;
    {memAddr, memLevel, opCode} = '0;
  end
  // one access; a branch not taken never shows its target here
  task automatic acc(input logic st, input logic [31:0] a, input logic [2:0] l, input logic s,
                     input logic ov, input logic sw);
    @(posedge mclk);
    memValid <= 1'b1;
    memStore <= st;
    memAddr <= a;
    memLevel <= l;
    memSecondary <= s;
    opValid <= ov;
    opCode <= `FPA_BAD_OPCODE; // undefined code
    switchReq <= sw;
    @(posedge mclk);
    {memValid, opValid, switchReq} <= 3'h0;
    memAddr <= ~a; // released bus does not keep the address
  endtask
  // external check pulse
  task automatic fault();
    @(posedge mclk);
    sysCheckIn <= 1'b1;
    @(posedge mclk);
    sysCheckIn <= 1'b0;
  endtask
endmodule

// File: verif/fpa_panel_properties.sv
`timescale 1ns/1ps
`include "fpa_defs.svh"
//////////////////////////////////////////////////////////////////////////////
module fpa_panel_checker #(
  parameter int NACT = 4,
  parameter int NSEL = 7,
  parameter int BLINK_CYC = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] busAddr,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [15:0] busRdata,
  input wire logic memValid,
  input wire logic opValid,
  input wire logic [15:0] opCode,
  input wire logic sysCheckIn,
  input wire logic switchReq,
  input wire logic intReq,
  input wire logic cmpStop,
  input wire logic progCheck,
  input wire logic switchGo,
  input wire logic sysCheckOut,
  input wire logic reg1Led,
  input wire logic reg2Led
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a hit in the same cycle as an exception or a switch pushes those back
  sequence hitOp;
    memValid && opValid && opCode == `FPA_BAD_OPCODE ##1 cmpStop;
  endsequence
  sequence hitSw;
    memValid && switchReq ##1 cmpStop;
  endsequence
  chk_hit_before_exc: assert property (hitOp |-> !progCheck ##1 progCheck)
    else $error("exception not after compare");
  chk_hit_before_swap: assert property (hitSw |-> !switchGo ##1 switchGo)
    else $error("switch not after compare");
  chk_exc_seen: assert property (opValid && opCode == `FPA_BAD_OPCODE |=> ##[0:1] progCheck)
    else $error("no program check");
  chk_cmp_cause: assert property (cmpStop |-> $past(memValid))
    else $error("compare without access");
  chk_bad_cmd: assert property (busWr && busAddr == {`FPA_DEV_ADDR, 8'hFF} |=> sysCheckOut)
    else $error("bad command not refused");
  chk_other_dev: assert property ((busWr || busRd) && busAddr[15:8] != `FPA_DEV_ADDR && !sysCheckIn
    |=> !sysCheckOut)
    else $error("foreign address answered");
  chk_rd_idle: assert property (!$past(busRd) |-> busRdata == 16'h0000)
    else $error("read data outside slot");
  chk_led_one: assert property (reg1Led != reg2Led)
    else $error("register indicators clash");
  chk_int_hold: assert property (intReq && !busWr |=> intReq)
    else $error("interrupt dropped");
endmodule

bind fpa_panel fpa_panel_checker #(.NACT(NACT), .NSEL(NSEL), .BLINK_CYC(BLINK_CYC)) u_chk (.mclk, .rst_n,
  .busAddr, .busWr, .busRd, .busRdata, .memValid, .opValid, .opCode, .sysCheckIn, .switchReq, .intReq,
  .cmpStop, .progCheck, .switchGo, .sysCheckOut, .reg1Led, .reg2Led);

// File: verif/fpa_panel_tb_top.sv
`timescale 1ns/1ps
`include "fpa_defs.svh"
module fpa_panel_tb_top;
  logic mclk, rst_n, busWr, busRd, keyValid, intReq, cmpStop, progCheck, switchGo, sysCheckOut, stopProc;
  logic reg1Led, reg2Led, attnLed, memValid, memStore, memSecondary, opValid, switchReq, sysCheckIn, a0;
  logic kbdLockLed;
  logic [15:0] busAddr, busWdata, busRdata, opCode, btn, rv;
  logic [31:0] memAddr, hexDisplay;
  logic [2:0] memLevel;
  logic [3:0] keyDigit;
  logic [7:0] dev;
  int n_errors, checks, tog;
  //////////////////////////////////////////////////////////////////////////////
  // short blink so the indicator toggles within a few cycles
  fpa_panel #(.BLINK_CYC(4)) dut (.mclk, .rst_n, .busAddr, .busWdata, .busWr, .busRd, .busRdata, .memValid,
    .memStore, .memAddr, .memLevel, .memSecondary, .opValid, .opCode, .sysCheckIn, .switchReq,
    .btnAction(btn[3:0]), .btnSelect(btn[10:4]), .btnStart(btn[11]), .btnEnable(btn[12]), .btnClear(btn[13]),
    .btnReg1(btn[14]), .btnReg2(btn[15]), .keyValid, .keyDigit, .intReq, .cmpStop, .progCheck, .switchGo,
    .sysCheckOut, .stopProc, .hexDisplay, .reg1Led, .reg2Led, .attnLed, .kbdLockLed);
  fpa_cpu cpu (.mclk, .memValid, .memStore, .memAddr, .memLevel, .memSecondary, .opValid, .opCode,
    .switchReq, .sysCheckIn);
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe; result sampled after the taking edge has landed
  task automatic bus(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge mclk);
    busAddr <= {dev, c};
    busWdata <= d;
    busWr <= w;
    busRd <= !w;
    @(posedge mclk);
    {busWr, busRd} <= 2'b00;
    #1;
    rv = busRdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // buttons are levels held over several cycles, like a finger
  task automatic press(input int k);
    @(posedge mclk);
    btn[k] <= 1'b1;
    repeat (3) @(posedge mclk);
    btn[k] <= 1'b0;
    idle(3);
  endtask
  // hex key held like a button, digit beside it
  task automatic key(input logic [3:0] d);
    @(posedge mclk);
    keyDigit <= d;
    keyValid <= 1'b1;
    repeat (3) @(posedge mclk);
    keyValid <= 1'b0;
    idle(3);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // whole run is under a thousand cycles
  initial begin
    #500000;
    n_errors++;
    results();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {busWr, busRd, keyValid, busAddr, busWdata, btn, keyDigit} = '0;
    dev = `FPA_DEV_ADDR;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    idle(1);
    chk({reg2Led, reg1Led}, 2'b01);
    // blink with the panel still disabled
    bus(1, `FPA_CMD_WR_CTRL, 16'h0010);
    tog = 0;
    a0 = attnLed;
    repeat (20) begin
      idle(1);
      tog += int'(attnLed !== a0);
      a0 = attnLed;
    end
    chk(tog > 2, 1'b1);
    dev = 8'h0B;
    bus(1, `FPA_CMD_WR_CTRL, 16'h0001);
    dev = `FPA_DEV_ADDR;
    bus(0, `FPA_CMD_RD_CTRL, 16'h0);
    chk(rv, 16'h0010);
    // fetch compare at addresses 0 and 0000FFFF
    bus(1, `FPA_CMD_SET_BASIC_STATUS_WORD, 16'h4000);
    bus(1, `FPA_CMD_WR_CTRL, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      bus(1, `FPA_CMD_WR_CMPLO, i ? 16'hFFFF : 16'h0000);
      cpu.acc(1'b0, i ? 32'hFFFF : 32'h0, 3'h1, 1'b0, 1'b0, 1'b0);
      idle(3);
      chk(intReq, 1'b1);
      bus(0, `FPA_CMD_RD_BASIC_STATUS_WORD, 16'h0);
      chk(rv, 16'h4001);
      bus(1, `FPA_CMD_CLR_BASIC_STATUS_WORD, 16'h0001);
      chk(intReq, 1'b0);
    end
    bus(1, `FPA_CMD_WR_CTRL, 16'h0002);
    cpu.acc(1'b0, 32'hFFFF, 3'h1, 1'b0, 1'b0, 1'b0);
    #1;
    chk(cmpStop, 1'b0);
    cpu.acc(1'b1, 32'hFFFF, 3'h1, 1'b0, 1'b0, 1'b0);
    #1;
    chk(cmpStop, 1'b1);
    bus(1, `FPA_CMD_WR_CTRL, 16'h0001);
    cpu.acc(1'b1, 32'hFFFF, 3'h1, 1'b0, 1'b0, 1'b0);
    #1;
    chk(cmpStop, 1'b0);
    // only the selected level on the secondary vector matches
    bus(1, `FPA_CMD_WR_CTRL, 16'h0001);
    bus(1, `FPA_CMD_WR_CSET, 16'h000B);
    for (int l = 1; l < 8; l++) begin
      for (int s = 0; s < 2; s++) begin
        cpu.acc(1'b0, 32'hFFFF, 3'(l), 1'(s), 1'b0, 1'b0);
        #1;
        chk(cmpStop, l == 3 && s == 1);
      end
    end
    bus(1, `FPA_CMD_WR_CSET, 16'h0000);
    cpu.acc(1'b0, 32'hFFFF, 3'h1, 1'b0, 1'b1, 1'b1);
    #1;
    chk({cmpStop, progCheck, switchGo}, 3'b100);
    idle(1);
    chk({progCheck, switchGo}, 2'b11);
    // stop on exception, then on an external check after a fresh reset
    bus(1, `FPA_CMD_WR_CTRL, 16'h0004);
    cpu.acc(1'b0, 32'h0, 3'h1, 1'b0, 1'b1, 1'b0);
    idle(2);
    chk(stopProc, 1'b1);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    bus(1, `FPA_CMD_WR_CTRL, 16'h0004);
    cpu.fault();
    idle(2);
    chk(stopProc, 1'b1);
    for (int c = 15; c < 257; c++) begin
      bus(1, 8'(c), 16'h0000);
      chk(sysCheckOut, 1'b1);
    end
    bus(0, `FPA_CMD_RD_BASIC_STATUS_WORD, 16'h0);
    chk(rv, 16'h3004);
    // display registers and panel buttons
    bus(1, `FPA_CMD_WR_CTRL, 16'h0000);
    bus(1, `FPA_CMD_WR_DLO, 16'h5678);
    bus(1, `FPA_CMD_WR_DHI, 16'h1234);
    bus(1, `FPA_CMD_WR_CTRL, 16'h0008);
    bus(1, `FPA_CMD_WR_DLO, 16'hBAD0);
    bus(1, `FPA_CMD_WR_DHI, 16'hBAD0);
    idle(2);
    chk({hexDisplay, reg2Led, reg1Led}, {32'hBAD0BAD0, 2'b10});
    bus(1, `FPA_CMD_WR_CTRL, 16'h0000);
    press(12);
    press(11);
    bus(0, `FPA_CMD_RD_BASIC_STATUS_WORD, 16'h0);
    chk({rv[14], rv[3], hexDisplay, reg1Led}, {2'b11, 32'h12345678, 1'b1});
    bus(1, `FPA_CMD_CLR_BASIC_STATUS_WORD, 16'h3FF7);
    chk(intReq, 1'b0);
    press(0);
    bus(0, `FPA_CMD_RD_BASIC_STATUS_WORD, 16'h0);
    chk({rv[4], intReq}, 2'b11);
    bus(1, `FPA_CMD_CLR_BASIC_STATUS_WORD, 16'h0FF0);
    press(6);
    bus(0, `FPA_CMD_RD_BASIC_STATUS_WORD, 16'h0);
    chk({rv[10:8], intReq}, 4'h6);
    press(11);
    chk(intReq, 1'b1);
    press(15);
    chk({hexDisplay, reg2Led}, {32'hBAD0BAD0, 1'b1});
    press(14);
    key(4'h9);
    chk({hexDisplay, reg1Led}, {32'h23456789, 1'b1});
    bus(1, `FPA_CMD_WR_CTRL, 16'h0018);
    press(13);
    bus(0, `FPA_CMD_RD_CTRL, 16'h0);
    chk({rv[4:3], hexDisplay, reg1Led}, {2'b00, 32'h0, 1'b1});
    bus(0, `FPA_CMD_RD_BASIC_STATUS_WORD, 16'h0);
    chk(rv[3], 1'b0);
    // locked keyboard: digit refused, indicator lit
    bus(1, `FPA_CMD_WR_CTRL, 16'h0020);
    key(4'h5);
    chk({hexDisplay, kbdLockLed}, {32'h0, 1'b1});
    results();
  end
endmodule
